// ==== rtl/low_power_clock_gating.v ====
// low-power mode and clock-gating controller with an axi4-lite register slave
// Notes on behaviour
// RULE_01: idle instruction stops core clock, output keeps running
// RULE_02: reset or interrupt ends idle, core clock restored
// RULE_03: two gateable domains: core and system
// RULE_04: first idle mode stops only the core domain
// RULE_05: second mode stops both, keeps watchdog, pll, oscillator
// RULE_06: halt also stops oscillator, pll and watchdog
// RULE_07: select bits 13:12: 00, 01, 1x choose mode
// RULE_08: wake sources differ per mode; halt: reset, protect
// RULE_09: software powers flash down before requesting halt
// RULE_10: six peripheral clock enables, all cleared at reset
// RULE_11: gate enables change only on clock edges, glitch-free
`timescale 1ns/1ps
`include "lowpower_clk_regs.vh"

module low_power_clock_gating (
	input  wire        clock,                  // controller clock, always running
	input  wire        rstn,                   // asynchronous reset, active low
	input  wire        idle_req,               // pulse: processor executes the idle instruction
	input  wire        periph_irq,             // peripheral interrupt request
	input  wire        ext_irq,                // external interrupt request
	input  wire        wake_irq,               // wake-up interrupt request
	input  wire        power_drive_protect_in, // power-drive-protection event
	input  wire [3:0]  awaddr,                 // axi write address
	input  wire        awvalid,                // axi write address valid
	output reg         awready,                // axi write address ready
	input  wire [31:0] wdata,                  // axi write data
	input  wire [3:0]  wstrb,                  // axi write byte strobes
	input  wire        wvalid,                 // axi write data valid
	output reg         wready,                 // axi write data ready
	output reg  [1:0]  bresp,                  // axi write response
	output reg         bvalid,                 // axi write response valid
	input  wire        bready,                 // axi write response ready
	input  wire [3:0]  araddr,                 // axi read address
	input  wire        arvalid,                // axi read address valid
	output reg         arready,                // axi read address ready
	output reg  [31:0] rdata,                  // axi read data
	output reg  [1:0]  rresp,                  // axi read response
	output reg         rvalid,                 // axi read data valid
	input  wire        rready,                 // axi read data ready
	output reg         core_clk_en_r,          // enable for core-domain gating cell
	output reg         sys_clk_en_r,           // enable for system-domain gating cell
	output reg         watchdog_clock_en_r,    // watchdog clock enable
	output reg         pll_en_r,               // pll enable
	output reg         osc_en_r,               // oscillator enable
	output reg  [5:0]  periph_clk_en_r,        // per-peripheral clock enables
	output reg  [1:0]  mode_r                  // current low-power state
);

	// register decode shared by the read and write paths
	function [1:0] reg_sel;
		input [3:0] addr;
		begin
			case (addr)
				`ADDR_SYS_CTRL:    reg_sel = 2'h1;
				`ADDR_MODE_STATUS: reg_sel = 2'h2;
				default:           reg_sel = 2'h0;
			endcase
		end
	endfunction

	reg  [15:0] system_ctrl_status_one_r; // system control register
	reg  [15:0] ctrl_nxt;
	reg         aw_have_r;
	reg  [3:0]  aw_addr_r;
	reg         w_have_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;
	reg         aw_have_nxt;
	reg         w_have_nxt;
	reg         bvalid_nxt;
	reg         rvalid_nxt;
	reg         do_write;
	reg  [1:0]  state_nxt;
	reg         wake;
	wire        lowpower_sel_hi = system_ctrl_status_one_r[`LPSEL_HI_BIT];
	wire        lowpower_sel_lo = system_ctrl_status_one_r[`LPSEL_LO_BIT];
	wire [15:0] ctrl_wmask      = `SYS_CTRL_WMASK; // writable bits, split per byte lane below

	// write channel bookkeeping: address and data accepted in either order
	always @* begin
		do_write    = aw_have_r & w_have_r & ~bvalid;
		aw_have_nxt = (aw_have_r | (awvalid & awready)) & ~do_write;
		w_have_nxt  = (w_have_r | (wvalid & wready)) & ~do_write;
		bvalid_nxt  = do_write | (bvalid & ~bready);
		rvalid_nxt  = (arvalid & arready) | (rvalid & ~rready);
	end

	// byte-lane merge into the control register, only writable bits change
	always @* begin
		ctrl_nxt = system_ctrl_status_one_r;
		if (do_write && reg_sel(aw_addr_r) == 2'h1) begin
			if (w_strb_r[0]) begin
				ctrl_nxt[7:0] = w_data_r[7:0] & ctrl_wmask[7:0];
			end
			if (w_strb_r[1]) begin
				ctrl_nxt[15:8] = w_data_r[15:8] & ctrl_wmask[15:8];
			end
		end
	end

	// write address and data holding, write response
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aw_have_r                <= 1'b0;
			aw_addr_r                <= 4'h0;
			w_have_r                 <= 1'b0;
			w_data_r                 <= 32'h0000_0000;
			w_strb_r                 <= 4'h0;
			awready                  <= 1'b0;
			wready                   <= 1'b0;
			bvalid                   <= 1'b0;
			bresp                    <= `RESP_OKAY;
			system_ctrl_status_one_r <= `SYS_CTRL_RESET; // see RULE_10
		end else begin
			if (awvalid && awready) begin
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			aw_have_r                <= aw_have_nxt;
			w_have_r                 <= w_have_nxt;
			awready                  <= ~aw_have_nxt & ~bvalid_nxt;
			wready                   <= ~w_have_nxt & ~bvalid_nxt;
			bvalid                   <= bvalid_nxt;
			system_ctrl_status_one_r <= ctrl_nxt;
			if (do_write) begin
				bresp <= (reg_sel(aw_addr_r) == 2'h1) ? `RESP_OKAY : `RESP_SLVERR; // status is read-only
			end
		end
	end

	// read channel: one cycle from address to data
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else begin
			rvalid  <= rvalid_nxt;
			arready <= ~rvalid_nxt;
			if (arvalid && arready) begin
				case (reg_sel(araddr))
					2'h1: begin
						rdata <= {16'h0000, system_ctrl_status_one_r};
						rresp <= `RESP_OKAY;
					end
					2'h2: begin
						rdata <= {20'h00000, periph_clk_en_r, osc_en_r, watchdog_clock_en_r, sys_clk_en_r,
							core_clk_en_r, mode_r}; // 20 + 6 + 4 + 2 bits
						rresp <= `RESP_OKAY;
					end
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= `RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// wake condition for the present state
	always @* begin
		case (mode_r)
			`ST_CORE_SLEEP: wake = periph_irq | ext_irq | power_drive_protect_in;  // see RULE_08
			`ST_SYS_SLEEP:  wake = wake_irq | ext_irq | power_drive_protect_in;    // see RULE_08
			`ST_HALT:       wake = power_drive_protect_in;                         // see RULE_08
			default:        wake = 1'b0;
		endcase
	end

	// mode selection on idle, exit on wake
	always @* begin
		state_nxt = mode_r;
		case (mode_r)
			`ST_RUN: begin
				if (idle_req) begin
					if (lowpower_sel_hi) begin
						state_nxt = `ST_HALT;           // see RULE_07
					end else if (lowpower_sel_lo) begin
						state_nxt = `ST_SYS_SLEEP;      // see RULE_07
					end else begin
						state_nxt = `ST_CORE_SLEEP;     // see RULE_01, see RULE_07
					end
				end
			end
			default: begin
				if (wake) begin
					state_nxt = `ST_RUN;                // see RULE_02
				end
			end
		endcase
	end

	// registered gate enables: each changes only at a clock edge, so a latch-based
	// gating cell downstream never cuts a pulse short
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode_r              <= `ST_RUN;
			core_clk_en_r       <= 1'b1;
			sys_clk_en_r        <= 1'b1;
			watchdog_clock_en_r <= 1'b1;
			pll_en_r            <= 1'b1;
			osc_en_r            <= 1'b1;
		end else begin
			mode_r              <= state_nxt;
			core_clk_en_r       <= (state_nxt == `ST_RUN);                                // see RULE_03, see RULE_11
			sys_clk_en_r        <= (state_nxt == `ST_RUN) || (state_nxt == `ST_CORE_SLEEP); // see RULE_04, see RULE_05
			watchdog_clock_en_r <= (state_nxt != `ST_HALT);                               // see RULE_06
			pll_en_r            <= (state_nxt != `ST_HALT);                               // see RULE_06
			osc_en_r            <= (state_nxt != `ST_HALT);                               // see RULE_06
		end
	end

	// peripheral clock enables follow their bit and the system domain
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_PCLK; gi = gi + 1) begin : g_pclk
			always @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					periph_clk_en_r[gi] <= 1'b0;                                          // see RULE_10
				end else begin
					periph_clk_en_r[gi] <= ctrl_nxt[`PCLK_LSB + gi] &
						((state_nxt == `ST_RUN) || (state_nxt == `ST_CORE_SLEEP));       // see RULE_10, see RULE_11
				end
			end
		end
	endgenerate

endmodule

// ==== inc/lowpower_clk_regs.vh ====
// register map, field positions and codes of the low-power clock controller
`ifndef LOWPOWER_CLK_REGS_VH
`define LOWPOWER_CLK_REGS_VH

`define ADDR_SYS_CTRL       4'h0
`define ADDR_MODE_STATUS    4'h4
`define SYS_CTRL_RESET      16'h0000
`define SYS_CTRL_WMASK      16'h30fc
`define LPSEL_HI_BIT        13
`define LPSEL_LO_BIT        12
`define PCLK_LSB            2
`define PCLK_MSB            7
`define NUM_PCLK            6
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`define ST_RUN              2'b00
`define ST_CORE_SLEEP       2'b01
`define ST_SYS_SLEEP        2'b10
`define ST_HALT             2'b11

`endif

// ==== dv/low_power_clock_gating_checker.sv ====
// assertions on low-power state and clock enables
`timescale 1ns/1ps
module low_power_clock_gating_checker (
	input wire       clock,                  // clock
	input wire       rstn,                   // reset, low
	input wire       idle_req,               // idle pulse
	input wire       periph_irq,             // periph irq
	input wire       ext_irq,                // ext irq
	input wire       wake_irq,               // wake irq
	input wire       power_drive_protect_in, // protect
	input wire       core_clk_en_r,          // core gate
	input wire       sys_clk_en_r,           // system gate
	input wire       watchdog_clock_en_r,    // watchdog
	input wire       pll_en_r,               // pll
	input wire       osc_en_r,               // oscillator
	input wire [5:0] periph_clk_en_r,        // periph gates
	input wire [1:0] mode_r                  // state
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// idle taken in run, and valid wake per sleep mode
	sequence s_idle; mode_r == 2'b00 && idle_req; endsequence
	sequence s_wk1; mode_r == 2'b01 && (periph_irq || ext_irq || power_drive_protect_in); endsequence
	sequence s_wk2; mode_r == 2'b10 && (wake_irq || ext_irq || power_drive_protect_in); endsequence
	a_idle_core_off: assert property (s_idle |=> !core_clk_en_r && mode_r != 2'b00)
		else $error("core clock kept on idle");
	a_core_sleep_gates: assert property (mode_r == 2'b01 |-> !core_clk_en_r && sys_clk_en_r && osc_en_r)
		else $error("core sleep gates wrong");
	a_sys_sleep_gates: assert property (mode_r == 2'b10 |->
		{core_clk_en_r, sys_clk_en_r, watchdog_clock_en_r, pll_en_r, osc_en_r} == 5'h07)
		else $error("system sleep gates wrong");
	a_halt_all_off: assert property (mode_r == 2'b11 |->
		{core_clk_en_r, sys_clk_en_r, watchdog_clock_en_r, pll_en_r, osc_en_r} == 5'h00)
		else $error("halt gates wrong");
	a_core_wake: assert property (s_wk1 |=> mode_r == 2'b00 && core_clk_en_r)
		else $error("core sleep not left");
	a_sys_wake: assert property (s_wk2 |=> mode_r == 2'b00 && sys_clk_en_r)
		else $error("system sleep not left");
	a_halt_hold: assert property (mode_r == 2'b11 && !power_drive_protect_in |=> mode_r == 2'b11)
		else $error("halt left without protect");
	a_periph_gated: assert property (!sys_clk_en_r |-> periph_clk_en_r == 6'h00)
		else $error("peripheral clock on in sleep");
endmodule
bind low_power_clock_gating low_power_clock_gating_checker low_power_clock_gating_checker_i (.clock, .rstn,
	.idle_req, .periph_irq, .ext_irq, .wake_irq, .power_drive_protect_in, .core_clk_en_r, .sys_clk_en_r,
	.watchdog_clock_en_r, .pll_en_r, .osc_en_r, .periph_clk_en_r, .mode_r);

// ==== dv/low_power_clock_gating_bench.sv ====
// self-checking bench for the low-power clock controller
`timescale 1ns/1ps
module low_power_clock_gating_bench;
	logic        clock = 0, rstn = 0, idle_req = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0]  src = 0, awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, core_en, sys_en, wd_en, pll_en, osc_en;
	logic [1:0]  bresp, rresp, mode_r;
	logic [5:0]  periph_en;
	int          error_cnt = 0, checked = 0;
	always #50 clock = ~clock;
	low_power_clock_gating low_power_clock_gating_i (.clock, .rstn, .idle_req, .periph_irq(src[0]),
		.ext_irq(src[1]), .wake_irq(src[2]), .power_drive_protect_in(src[3]), .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .core_clk_en_r(core_en), .sys_clk_en_r(sys_en), .watchdog_clock_en_r(wd_en),
		.pll_en_r(pll_en), .osc_en_r(osc_en), .periph_clk_en_r(periph_en), .mode_r);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// bus write: channels released as taken, response compared
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		tb = 0;
		@(posedge clock); // lets the previous release settle before bready rises again
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!tb) begin
			@(negedge clock);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb) chk("bresp", er, bresp);
			@(posedge clock);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tb) bready <= 0;
		end
	endtask
	// bus read: data and response compared
	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tv;
		tv = 0;
		@(posedge clock); // lets the previous release settle before rready rises again
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!tv) begin
			@(negedge clock);
			ta = arvalid && arready;
			tv = rvalid;
			if (tv) chk("rdata", ed, rdata);
			if (tv) chk("rresp", er, rresp);
			@(posedge clock);
			if (ta) arvalid <= 0;
			if (tv) rready <= 0;
		end
	endtask
	// enter a mode, offer a foreign wake source, then a valid one
	task automatic sleep(input logic [1:0] sel, em, input logic [4:0] ee, input logic [3:0] bad, ok);
		wr(4'h0, {18'h0, sel, 12'h0fc}, 2'b00);
		idle_req <= 1;
		@(posedge clock);
		idle_req <= 0;
		src <= bad;
		#1 chk("mode", em, mode_r);
		chk("gates", ee, {core_en, sys_en, wd_en, pll_en, osc_en});
		repeat (2) @(posedge clock);
		src <= ok;
		#1 chk("mode held", em, mode_r);
		@(posedge clock);
		src <= 0;
		#1 chk("mode woken", 0, mode_r);
		@(posedge clock);
		#1 chk("periph", 6'h3f, periph_en);
		@(posedge clock);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1;
		repeat (2) @(posedge clock);
		rd(4'h0, 32'h0, 2'b00);
		rd(4'h4, 32'h3c, 2'b00);
		wr(4'h0, 32'hffffffff, 2'b00);
		rd(4'h0, 32'h30fc, 2'b00);
		rd(4'h4, 32'hffc, 2'b00);
		wr(4'h4, 32'h0, 2'b10);
		rd(4'h8, 32'h0, 2'b10);
		sleep(2'b00, 2'b01, 5'h0f, 4'h4, 4'h1);
		sleep(2'b01, 2'b10, 5'h07, 4'h1, 4'h4);
		sleep(2'b10, 2'b11, 5'h00, 4'h7, 4'h8); // flash taken as already off
		sleep(2'b11, 2'b11, 5'h00, 4'h7, 4'h8);
		sleep(2'b00, 2'b01, 5'h0f, 4'h0, 4'h8);
		sleep(2'b01, 2'b10, 5'h07, 4'h1, 4'h2);
		sleep(2'b00, 2'b01, 5'h0f, 4'h4, 4'h2);
		// reset taken while halted
		wr(4'h0, 32'h20fc, 2'b00);
		idle_req <= 1;
		@(posedge clock);
		idle_req <= 0;
		rstn <= 0;
		repeat (3) @(posedge clock);
		rstn <= 1;
		repeat (2) @(posedge clock);
		rd(4'h4, 32'h3c, 2'b00);
		rd(4'h0, 32'h0, 2'b00);
		results;
	end
	// cut a hang short
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		results;
	end
endmodule
